// >>> hdl/gpp_regs.svh
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define GPP_OFS_DIR_A     8'h00
`define GPP_OFS_DIR_B     8'h04
`define GPP_OFS_DIR_C     8'h08
`define GPP_OFS_ALT_A     8'h0c
`define GPP_OFS_ALT_B     8'h10
`define GPP_OFS_ALT_C     8'h14
`define GPP_OFS_DRV_A     8'h18
`define GPP_OFS_DRV_B     8'h1c
`define GPP_OFS_DRV_C     8'h20
`define GPP_OFS_LVL_A     8'h24
`define GPP_OFS_LVL_B     8'h28
`define GPP_OFS_LVL_C     8'h2c
`define GPP_OFS_CHG_A     8'h30
`define GPP_OFS_CHG_B     8'h34
`define GPP_OFS_CHG_C     8'h38
`define GPP_OFS_BUFDIS_A  8'h3c
`define GPP_OFS_RADIO     8'h40
`define GPP_OFS_IRQ_STAT  8'h44
`define GPP_OFS_IRQ_MASK  8'h48
// ****************************************
// Field positions and reset values
// ****************************************
`define GPP_RADIO_AMP_BIT 6
`define GPP_RADIO_ANT_BIT 7
`define GPP_PB_AMP_PIN    2
`define GPP_PB_ANT_PIN    3
`define GPP_RST_BYTE      8'h00
`define GPP_RST_MASK      3'h0
`define GPP_NUM_PORTS     3
`endif

// >>> hdl/gpp_pkg.sv
package gpp_pkg;
  typedef logic [7:0] gpp_byte_t;
  typedef enum logic [1:0] {
    GPP_BUS_IDLE = 2'b00,
    GPP_BUS_ACK  = 2'b01
  } gpp_bus_state_t;
endpackage : gpp_pkg

// >>> hdl/gpp_sync.sv
`timescale 1ns/1ps
// ****************************************
// Three-stage input synchroniser
// ****************************************
module gpp_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] pin_i,
  input  wire logic [7:0] in_en_i,
  output logic      [7:0] level_o,
  output logic      [7:0] change_o
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic [7:0] lvl_r;
  logic [7:0] s1_nxt;
  logic [7:0] lvl_nxt;
  logic [7:0] chg_nxt;
  logic [7:0] chg_r;

  // Disabled buffer reads low so an analog level draws no current and fires no edge
  always_comb begin
    s1_nxt  = pin_i & in_en_i;                    // RQ5
    lvl_nxt = lvl_r;
    chg_nxt = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];                     // RQ12
        chg_nxt[i] = s3_r[i] ^ lvl_r[i];          // RQ12
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= 8'h00;
      s2_r  <= 8'h00;
      s3_r  <= 8'h00;
      lvl_r <= 8'h00;
      chg_r <= 8'h00;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign level_o  = lvl_r;
  assign change_o = chg_r;
endmodule : gpp_sync

// >>> hdl/gpp_pin_mux.sv
`timescale 1ns/1ps
// ****************************************
// Per-port drive and pull-up selection
// ****************************************
module gpp_pin_mux (
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] alt_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] periph_i,
  output logic      [7:0] out_o,
  output logic      [7:0] oe_o,
  output logic      [7:0] pull_o
);
  always_comb begin
    oe_o   = dir_i;                                         // RQ1
    out_o  = (alt_i & periph_i) | (~alt_i & drv_i);         // RQ2 RQ3
    pull_o = ~dir_i & drv_i;                                // RQ4
  end
endmodule : gpp_pin_mux

// >>> hdl/gpp_port.sv
`timescale 1ns/1ps
`include "gpp_regs.svh"
// Contract
// RQ1 - Output-select 1 drives pin, 0 input
// RQ2 - Alternate bit picks peripheral output over GPIO
// RQ3 - GPIO output drives the drive/pull-up value
// RQ4 - Input pull-up follows drive/pull-up bit
// RQ5 - Port A buffer-disable turns off input
// RQ6 - Enabled pins interrupt on any change
// RQ7 - Readable level of each pin
// RQ8 - Level read clears port's pending change; code clears it only while the port has a change-enable bit set
// RQ9 - PB2 amp output needs radio bit6, dir2
// RQ10 - PB3 antenna output needs radio bit7, dir3
// RQ11 - Software floats radio pins via output-select
// RQ12 - Inputs synchronised, change between consecutive samples
module gpp_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  pa_i,
  input  wire logic [7:0]  pb_i,
  input  wire logic [7:0]  pc_i,
  input  wire logic [7:0]  periph_a_i,
  input  wire logic [7:0]  periph_b_i,
  input  wire logic [7:0]  periph_c_i,
  input  wire logic        amp_control_out_i,
  input  wire logic        antenna_switch_out_i,
  output logic      [7:0]  pa_o,
  output logic      [7:0]  pa_oe_o,
  output logic      [7:0]  pa_pull_o,
  output logic      [7:0]  pb_o,
  output logic      [7:0]  pb_oe_o,
  output logic      [7:0]  pb_pull_o,
  output logic      [7:0]  pc_o,
  output logic      [7:0]  pc_oe_o,
  output logic      [7:0]  pc_pull_o,
  output logic             irq_o
);
  // ****************************************
  // State
  // ****************************************
  gpp_pkg::gpp_byte_t     dir_r      [3];
  gpp_pkg::gpp_byte_t     alt_r      [3];
  gpp_pkg::gpp_byte_t     drv_r      [3];
  gpp_pkg::gpp_byte_t     chg_en_r   [3];
  gpp_pkg::gpp_byte_t     dir_nxt    [3];
  gpp_pkg::gpp_byte_t     alt_nxt    [3];
  gpp_pkg::gpp_byte_t     drv_nxt    [3];
  gpp_pkg::gpp_byte_t     chg_en_nxt [3];
  gpp_pkg::gpp_byte_t     bufdis_r;
  gpp_pkg::gpp_byte_t     bufdis_nxt;
  gpp_pkg::gpp_byte_t     radio_r;
  gpp_pkg::gpp_byte_t     radio_nxt;
  logic [2:0]             stat_r;
  logic [2:0]             stat_nxt;
  logic [2:0]             mask_r;
  logic [2:0]             mask_nxt;
  gpp_pkg::gpp_bus_state_t bus_r;
  gpp_pkg::gpp_bus_state_t bus_nxt;
  logic [31:0]            rdat_r;
  logic [31:0]            rdat_nxt;
  logic                   irq_r;
  gpp_pkg::gpp_byte_t     lvl      [3];
  gpp_pkg::gpp_byte_t     chg      [3];
  gpp_pkg::gpp_byte_t     pin_in   [3];
  gpp_pkg::gpp_byte_t     in_en    [3];
  gpp_pkg::gpp_byte_t     periph   [3];
  gpp_pkg::gpp_byte_t     mux_out  [3];
  gpp_pkg::gpp_byte_t     mux_oe   [3];
  gpp_pkg::gpp_byte_t     mux_pull [3];
  gpp_pkg::gpp_byte_t     out_r    [3];
  gpp_pkg::gpp_byte_t     oe_r     [3];
  gpp_pkg::gpp_byte_t     pull_r   [3];
  logic                   acc;
  logic                   wr;
  logic                   rd;
  logic                   amp_route;
  logic                   ant_route;

  assign pin_in[0] = pa_i;
  assign pin_in[1] = pb_i;
  assign pin_in[2] = pc_i;
  assign in_en[0]  = ~bufdis_r;                                  // RQ5
  assign in_en[1]  = 8'hff;
  assign in_en[2]  = 8'hff;

  // Radio functions override the peripheral on PB2/PB3 only when both bits are set
  assign amp_route = radio_r[`GPP_RADIO_AMP_BIT] & dir_r[1][`GPP_PB_AMP_PIN];  // RQ9
  assign ant_route = radio_r[`GPP_RADIO_ANT_BIT] & dir_r[1][`GPP_PB_ANT_PIN];  // RQ10

  always_comb begin
    periph[0] = periph_a_i;
    periph[1] = periph_b_i;
    periph[2] = periph_c_i;
  end

  // ****************************************
  // Per-port pin logic
  // ****************************************
  generate
    for (genvar p = 0; p < `GPP_NUM_PORTS; p++) begin : g_port
      gpp_sync u_sync (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pin_i    (pin_in[p]),
        .in_en_i  (in_en[p]),
        .level_o  (lvl[p]),
        .change_o (chg[p])
      );
      gpp_pin_mux u_mux (
        .dir_i    (dir_r[p]),
        .alt_i    (alt_r[p]),
        .drv_i    (drv_r[p]),
        .periph_i (periph[p]),
        .out_o    (mux_out[p]),
        .oe_o     (mux_oe[p]),
        .pull_o   (mux_pull[p])
      );
    end
  endgenerate

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic gpp_pkg::gpp_byte_t merge8(input gpp_pkg::gpp_byte_t old_v,
                                                input logic [31:0] d,
                                                input logic [3:0] sel);
    merge8 = sel[0] ? d[7:0] : old_v;
  endfunction : merge8

  assign acc = wb_cyc_i & wb_stb_i & (bus_r == gpp_pkg::GPP_BUS_IDLE);
  assign wr  = acc & wb_we_i;
  assign rd  = acc & ~wb_we_i;

  always_comb begin
    logic [2:0] lvl_read;
    lvl_read   = 3'h0;
    dir_nxt    = dir_r;
    alt_nxt    = alt_r;
    drv_nxt    = drv_r;
    chg_en_nxt = chg_en_r;
    bufdis_nxt = bufdis_r;
    radio_nxt  = radio_r;
    mask_nxt   = mask_r;
    rdat_nxt   = 32'h0000_0000;
    bus_nxt    = acc ? gpp_pkg::GPP_BUS_ACK : gpp_pkg::GPP_BUS_IDLE;
    for (int p = 0; p < 3; p++) begin
      if (wb_adr_i == `GPP_OFS_DIR_A + 8'(4 * p)) begin
        rdat_nxt[7:0] = dir_r[p];
        if (wr) dir_nxt[p] = merge8(dir_r[p], wb_dat_i, wb_sel_i);          // RQ1
      end else if (wb_adr_i == `GPP_OFS_ALT_A + 8'(4 * p)) begin
        rdat_nxt[7:0] = alt_r[p];
        if (wr) alt_nxt[p] = merge8(alt_r[p], wb_dat_i, wb_sel_i);          // RQ2
      end else if (wb_adr_i == `GPP_OFS_DRV_A + 8'(4 * p)) begin
        rdat_nxt[7:0] = drv_r[p];
        if (wr) drv_nxt[p] = merge8(drv_r[p], wb_dat_i, wb_sel_i);          // RQ3
      end else if (wb_adr_i == `GPP_OFS_LVL_A + 8'(4 * p)) begin
        rdat_nxt[7:0] = lvl[p];                                             // RQ7
        lvl_read[p]   = rd;
      end else if (wb_adr_i == `GPP_OFS_CHG_A + 8'(4 * p)) begin
        rdat_nxt[7:0] = chg_en_r[p];
        if (wr) chg_en_nxt[p] = merge8(chg_en_r[p], wb_dat_i, wb_sel_i);    // RQ6
      end
    end
    if (wb_adr_i == `GPP_OFS_BUFDIS_A) begin
      rdat_nxt[7:0] = bufdis_r;
      if (wr) bufdis_nxt = merge8(bufdis_r, wb_dat_i, wb_sel_i);            // RQ5
    end else if (wb_adr_i == `GPP_OFS_RADIO) begin
      rdat_nxt[7:0] = radio_r;
      if (wr) radio_nxt = merge8(radio_r, wb_dat_i, wb_sel_i);
    end else if (wb_adr_i == `GPP_OFS_IRQ_STAT) begin
      rdat_nxt[2:0] = stat_r;
    end else if (wb_adr_i == `GPP_OFS_IRQ_MASK) begin
      rdat_nxt[2:0] = mask_r;
      if (wr && wb_sel_i[0]) mask_nxt = wb_dat_i[2:0];
    end
    // Set beats clear: a change in the cycle of a clear stays pending
    for (int p = 0; p < 3; p++) begin
      stat_nxt[p] = stat_r[p];
      if (lvl_read[p] && (chg_en_r[p] != 8'h00)) stat_nxt[p] = 1'b0;        // RQ8
      if (wr && wb_sel_i[0] && wb_adr_i == `GPP_OFS_IRQ_STAT && wb_dat_i[p]) begin
        stat_nxt[p] = 1'b0;
      end
      if ((chg[p] & chg_en_r[p]) != 8'h00) stat_nxt[p] = 1'b1;              // RQ6
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 3; p++) begin
        dir_r[p]    <= `GPP_RST_BYTE;
        alt_r[p]    <= `GPP_RST_BYTE;
        drv_r[p]    <= `GPP_RST_BYTE;
        chg_en_r[p] <= `GPP_RST_BYTE;
        out_r[p]    <= `GPP_RST_BYTE;
        oe_r[p]     <= `GPP_RST_BYTE;
        pull_r[p]   <= `GPP_RST_BYTE;
      end
      bufdis_r <= `GPP_RST_BYTE;
      radio_r  <= `GPP_RST_BYTE;
      stat_r   <= `GPP_RST_MASK;
      mask_r   <= `GPP_RST_MASK;
      bus_r    <= gpp_pkg::GPP_BUS_IDLE;
      rdat_r   <= 32'h0000_0000;
      irq_r    <= 1'b0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        dir_r[p]    <= dir_nxt[p];
        alt_r[p]    <= alt_nxt[p];
        drv_r[p]    <= drv_nxt[p];
        chg_en_r[p] <= chg_en_nxt[p];
        out_r[p]    <= mux_out[p];
        oe_r[p]     <= mux_oe[p];
        pull_r[p]   <= mux_pull[p];
      end
      // Radio overrides win over port B alternate and GPIO drive
      if (amp_route) out_r[1][`GPP_PB_AMP_PIN] <= amp_control_out_i;        // RQ9
      if (ant_route) out_r[1][`GPP_PB_ANT_PIN] <= antenna_switch_out_i;     // RQ10
      bufdis_r <= bufdis_nxt;
      radio_r  <= radio_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      bus_r    <= bus_nxt;
      rdat_r   <= rdat_nxt;
      irq_r    <= (stat_nxt & mask_nxt) != 3'h0;
    end
  end

  // Pin outputs lag the control registers by one cycle to stay flop-driven; irq_o does not lag
  assign wb_ack_o  = (bus_r == gpp_pkg::GPP_BUS_ACK);
  assign wb_dat_o  = rdat_r;
  assign pa_o      = out_r[0];
  assign pa_oe_o   = oe_r[0];
  assign pa_pull_o = pull_r[0];
  assign pb_o      = out_r[1];
  assign pb_oe_o   = oe_r[1];
  assign pb_pull_o = pull_r[1];
  assign pc_o      = out_r[2];
  assign pc_oe_o   = oe_r[2];
  assign pc_pull_o = pull_r[2];
  assign irq_o     = irq_r;
endmodule : gpp_port

// >>> sim/gpp_port_checker.sv
`timescale 1ns/1ps
`include "gpp_regs.svh"
// ****************************************
// Port pin checker
// ****************************************
module gpp_port_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  pa_i,
  input wire logic [7:0]  pb_i,
  input wire logic [7:0]  pc_i,
  input wire logic [7:0]  periph_a_i,
  input wire logic [7:0]  periph_b_i,
  input wire logic [7:0]  periph_c_i,
  input wire logic        amp_control_out_i,
  input wire logic        antenna_switch_out_i,
  input wire logic [7:0]  pa_o,
  input wire logic [7:0]  pa_oe_o,
  input wire logic [7:0]  pa_pull_o,
  input wire logic [7:0]  pb_o,
  input wire logic [7:0]  pb_oe_o,
  input wire logic [7:0]  pb_pull_o,
  input wire logic [7:0]  pc_o,
  input wire logic [7:0]  pc_oe_o,
  input wire logic [7:0]  pc_pull_o,
  input wire logic        irq_o
);
  logic [7:0]  sh_r [0:18];
  logic [7:0]  sh_nxt [0:18];
  logic [7:0]  ea, eb, ec;
  logic [23:0] eo, ep;
  logic        tk;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Shadow of written bytes; status writes land here too but are never used
  always_comb begin
    sh_nxt = sh_r;
    if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i < 8'h4c && wb_adr_i[1:0] == 2'h0) begin
      sh_nxt[wb_adr_i[6:2]] = wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= '{default: 8'h00};
    end else begin
      sh_r <= sh_nxt;
    end
  end
  assign ea = (sh_r[3] & periph_a_i) | (~sh_r[3] & sh_r[6]);
  assign ec = (sh_r[5] & periph_c_i) | (~sh_r[5] & sh_r[8]);
  always_comb begin
    eb = (sh_r[4] & periph_b_i) | (~sh_r[4] & sh_r[7]);
    if (sh_r[16][`GPP_RADIO_AMP_BIT]) eb[`GPP_PB_AMP_PIN] = amp_control_out_i;
    if (sh_r[16][`GPP_RADIO_ANT_BIT]) eb[`GPP_PB_ANT_PIN] = antenna_switch_out_i;
  end
  assign eo = {sh_r[2], sh_r[1], sh_r[0]};
  assign ep = {~sh_r[2] & sh_r[8], ~sh_r[1] & sh_r[7], ~sh_r[0] & sh_r[6]};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Outputs are only judged once the cause has settled past the two-cycle path
  sequence s_quiet;
    $stable({ea, eb, ec, eo, ep}) [*2];
  endsequence
  property p_oe_dir; s_quiet |-> {pc_oe_o, pb_oe_o, pa_oe_o} == eo; endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("output enable differs from direction");
  property p_out_a; s_quiet |-> ((pa_o ^ ea) & sh_r[0]) == 8'h00; endproperty
  a_out_a: assert property (p_out_a) else $error("port a drive value wrong");
  property p_out_c; s_quiet |-> ((pc_o ^ ec) & sh_r[2]) == 8'h00; endproperty
  a_out_c: assert property (p_out_c) else $error("port c drive value wrong");
  property p_radio; s_quiet |-> ((pb_o ^ eb) & sh_r[1]) == 8'h00; endproperty
  a_radio: assert property (p_radio) else $error("port b radio route wrong");
  property p_pull; s_quiet |-> {pc_pull_o, pb_pull_o, pa_pull_o} == ep; endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable wrong");
  // The interrupt flop is loaded from the new mask, so compare against the current shadow
  property p_irq_mask; irq_o |-> sh_r[18][2:0] != 3'h0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all masked");
  property p_ack_next; tk |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
endmodule : gpp_port_checker

bind gpp_port gpp_port_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pa_i(pa_i), .pb_i(pb_i),
  .pc_i(pc_i), .periph_a_i(periph_a_i), .periph_b_i(periph_b_i), .periph_c_i(periph_c_i),
  .amp_control_out_i(amp_control_out_i), .antenna_switch_out_i(antenna_switch_out_i),
  .pa_o(pa_o), .pa_oe_o(pa_oe_o), .pa_pull_o(pa_pull_o), .pb_o(pb_o), .pb_oe_o(pb_oe_o),
  .pb_pull_o(pb_pull_o), .pc_o(pc_o), .pc_oe_o(pc_oe_o), .pc_pull_o(pc_pull_o),
  .irq_o(irq_o));

// >>> sim/gpp_board.sv
`timescale 1ns/1ps
// ****************************************
// Board side of one port
// ****************************************
module gpp_board (
  input  wire logic       clk_i,
  input  wire logic [7:0] o_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pull_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pin_o
);
  logic flt_r = 1'b0;
  // A floating pin toggles every cycle, so the synchroniser never settles and holds its last level
  always_ff @(posedge clk_i) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) pin_o[i] = o_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_i[i];
      else if (pull_i[i]) pin_o[i] = 1'b1;
      else pin_o[i] = flt_r;
    end
  end
endmodule : gpp_board

// >>> sim/gpp_port_tb.sv
`timescale 1ns/1ps
`include "gpp_regs.svh"
// ****************************************
// Port pin testbench
// ****************************************
module gpp_port_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, amp = 1'b0, ant = 1'b0, ack, irq;
  logic [7:0]  adr = 8'h00, got, pa, pb, pc, pao, pbo, pco, paoe, pboe, pcoe;
  logic [7:0]  papu, pbpu, pcpu, pera = 8'h00, perb = 8'h00, perc = 8'h00;
  logic [7:0]  exta = 8'h00, extb = 8'h00, extc = 8'h00, exten = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  int          err_total = 0;
  int          n_compared = 0;
  always #50 clk_i = ~clk_i;
  gpp_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pa_i(pa), .pb_i(pb), .pc_i(pc), .periph_a_i(pera), .periph_b_i(perb),
    .periph_c_i(perc), .amp_control_out_i(amp), .antenna_switch_out_i(ant), .pa_o(pao),
    .pa_oe_o(paoe), .pa_pull_o(papu), .pb_o(pbo), .pb_oe_o(pboe), .pb_pull_o(pbpu),
    .pc_o(pco), .pc_oe_o(pcoe), .pc_pull_o(pcpu), .irq_o(irq));
  gpp_board i_ba (.clk_i(clk_i), .o_i(pao), .oe_i(paoe), .pull_i(papu), .ext_i(exta),
    .ext_en_i(exten), .pin_o(pa));
  gpp_board i_bb (.clk_i(clk_i), .o_i(pbo), .oe_i(pboe), .pull_i(pbpu), .ext_i(extb),
    .ext_en_i(exten), .pin_o(pb));
  gpp_board i_bc (.clk_i(clk_i), .o_i(pco), .oe_i(pcoe), .pull_i(pcpu), .ext_i(extc),
    .ext_en_i(exten), .pin_o(pc));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // Only the watchdog ends a wait; the latency is judged after the answer
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    got = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n, 2);
    @(posedge clk_i);
  endtask : bus
  task automatic t_regs;
    bus(1'b0, `GPP_OFS_DIR_A, 8'h00);
    chk(got, `GPP_RST_BYTE);
    bus(1'b1, 8'h4c, 8'hff);
    bus(1'b0, 8'h4c, 8'h00);
    chk(got, 8'h00);
    chk({paoe, pboe, pcoe, irq}, 25'h0);
  endtask : t_regs
  task automatic t_out;
    bus(1'b1, `GPP_OFS_DIR_A, 8'hff);
    bus(1'b1, `GPP_OFS_DRV_A, 8'ha5);
    bus(1'b1, `GPP_OFS_ALT_A, 8'h0f);
    pera <= 8'h3c;
    repeat (3) @(posedge clk_i);
    chk(paoe, 8'hff);
    chk(pao, 8'hac);
  endtask : t_out
  task automatic t_pull;
    bus(1'b1, `GPP_OFS_DIR_C, 8'h0f);
    bus(1'b1, `GPP_OFS_DRV_C, 8'hf0);
    repeat (3) @(posedge clk_i);
    chk(pcpu, 8'hf0);
    chk({pcoe, pco[3:0]}, 12'h0f0);
  endtask : t_pull
  task automatic t_radio;
    bus(1'b1, `GPP_OFS_DRV_B, 8'h08);
    bus(1'b1, `GPP_OFS_DIR_B, 8'h0c);
    bus(1'b1, `GPP_OFS_RADIO, 8'hc0);
    amp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(pbo[3:2], 2'b01);
    bus(1'b1, `GPP_OFS_RADIO, 8'h40);
    repeat (3) @(posedge clk_i);
    chk(pbo[3:2], 2'b11);
    bus(1'b1, `GPP_OFS_DIR_B, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(pboe, 8'h00);
  endtask : t_radio
  task automatic t_level;
    exten <= 8'hff;
    extb <= 8'h5a;
    repeat (8) @(posedge clk_i);
    bus(1'b0, `GPP_OFS_LVL_B, 8'h00);
    chk(got, 8'h5a);
    bus(1'b0, `GPP_OFS_LVL_A, 8'h00);
    chk(got, 8'hac);
    bus(1'b1, `GPP_OFS_BUFDIS_A, 8'hff);
    repeat (8) @(posedge clk_i);
    bus(1'b0, `GPP_OFS_LVL_A, 8'h00);
    chk(got, 8'h00);
  endtask : t_level
  task automatic t_irq;
    bus(1'b1, `GPP_OFS_CHG_C, 8'h10);
    bus(1'b1, `GPP_OFS_IRQ_MASK, 8'h04);
    extc <= 8'h10;
    repeat (10) @(posedge clk_i);
    chk(irq, 1'b1);
    bus(1'b0, `GPP_OFS_LVL_C, 8'h00);
    chk(got, 8'h10);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    bus(1'b1, `GPP_OFS_IRQ_MASK, 8'h00);
    extc <= 8'h00;
    repeat (10) @(posedge clk_i);
    chk(irq, 1'b0);
    bus(1'b0, `GPP_OFS_IRQ_STAT, 8'h00);
    chk(got, 8'h04);
    bus(1'b1, `GPP_OFS_IRQ_STAT, 8'h04);
    bus(1'b0, `GPP_OFS_IRQ_STAT, 8'h00);
    chk(got, 8'h00);
  endtask : t_irq
  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_out;
    t_pull;
    t_radio;
    t_level;
    t_irq;
    end_sim;
  end
  // Whole run needs about 140 cycles; twenty times that means a hang
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    $display("wrong value at %0t: timeout", $time);
    end_sim;
  end
endmodule : gpp_port_tb
